// [rps_top.sv]
// Reset, power-up delay and supply-dip sequencer with Avalon-MM registers
`timescale 1ns/1ps
module rps_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ext_reset_n_pin,
  input  wire logic        i_supply_ok,
  input  wire logic        i_below_threshold,
  input  wire logic        i_supply_grounded,
  input  wire logic        i_low_freq_internal_osc,
  input  wire logic        i_prog_mode,
  input  wire logic        i_bulk_erase,
  input  wire logic        i_wdt_reset,
  input  wire logic        i_sleep,
  input  wire logic [15:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_chip_reset,
  output logic             o_brownout_det_en,
  output logic [7:0]       o_brownout_trim,
  output logic             o_pin3_pullup_en,
  output logic             o_pin3_oe_n
);
  // Input synchronisers
  localparam int unsigned NIN_W = rps_pkg::NIN;
  logic [NIN_W-1:0] raw_in;
  wire  [NIN_W-1:0] clean_in;

  assign raw_in = {i_prog_mode, i_low_freq_internal_osc, i_supply_grounded,
                   i_below_threshold, i_supply_ok, i_ext_reset_n_pin};

  genvar g;
  generate
    for (g = 0; g < NIN_W; g++) begin : g_in
      rps_filt_if fif ();
      assign fif.raw     = raw_in[g];
      assign clean_in[g] = fif.clean;
      rps_sync_filt #(
        .FILT    (rps_pkg::FILT_LEN[g]),
        .RST_VAL (rps_pkg::IN_RST_VAL[g])
      ) u_filt (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .port  (fif.filt)
      );
    end
  endgenerate

  wire pin3_s   = clean_in[rps_pkg::IN_PIN3];
  wire sup_ok_s = clean_in[rps_pkg::IN_SUP_OK];
  wire below_s  = clean_in[rps_pkg::IN_BELOW];
  wire ground_s = clean_in[rps_pkg::IN_GROUND];
  wire lfosc_s  = clean_in[rps_pkg::IN_LFOSC];
  wire prog_s   = clean_in[rps_pkg::IN_PROG];

  // Configuration and status storage
  logic [3:0]             cfg_r;
  logic [7:0]             cal_r;
  logic [2:0]             power_control_reg_r;
  rps_pkg::rps_state_t    st_r;
  rps_pkg::rps_state_t    st_nxt;
  logic                   armed_r;
  logic [rps_pkg::CNT_W-1:0]  gnd_cnt_r;
  logic [rps_pkg::CNT_W-1:0]  dip_cnt_r;
  logic [rps_pkg::POWERUP_DELAY_TIMER_W-1:0] powerup_delay_timer_cnt_r;
  logic                   lf_prev_r;
  logic                   wait_r;
  logic [31:0]            rdata_r;

  // Fuse decode
  wire powerup_delay_timer_en   = !cfg_r[rps_pkg::CFG_POWERUP_DELAY_TIMER_DIS];
  wire ext_reset_pin_enable     = cfg_r[rps_pkg::CFG_EXT_RESET_PIN_ENABLE];
  wire [1:0] bor_mode = cfg_r[rps_pkg::CFG_BOR_HI:rps_pkg::CFG_BOR_LO];
  wire soft_en   = power_control_reg_r[rps_pkg::POWER_CONTROL_REG_SOFT_BROWNOUT_ENABLE];

  // Detector enable per mode
  wire mode_soft = (bor_mode == rps_pkg::BOR_SOFT);
  wire mode_wake = (bor_mode == rps_pkg::BOR_WAKE);
  wire mode_on   = (bor_mode == rps_pkg::BOR_ON);
  wire bor_en    = mode_on
                 | (mode_soft & soft_en)
                 | (mode_wake & !i_sleep);

  // Reset causes
  wire por_cond = armed_r & !sup_ok_s;
  wire ext_low  = ext_reset_pin_enable & !pin3_s;
  wire bor_trip = (dip_cnt_r == rps_pkg::CNT_W'(rps_pkg::BOR_MIN_CYC));
  wire gnd_done = (gnd_cnt_r == rps_pkg::CNT_W'(rps_pkg::POR_REARM_CYC));
  wire lf_tick  = lfosc_s & !lf_prev_r;
  wire powerup_delay_timer_end = (powerup_delay_timer_cnt_r == rps_pkg::POWERUP_DELAY_TIMER_W'(rps_pkg::POWERUP_DELAY_TIMER_LF_CYC - 1));
  wire powerup_delay_timer_done = powerup_delay_timer_end & lf_tick;
  wire in_powerup_delay_timer  = (st_r == rps_pkg::ST_POWERUP_DELAY_TIMER);
  rps_pkg::rps_state_t after_sup;
  assign after_sup = powerup_delay_timer_en ? rps_pkg::ST_POWERUP_DELAY_TIMER : rps_pkg::ST_RUN;

  // Power-on detector re-arm: only a long stay at ground re-arms it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gnd_cnt_r <= '0;
    end else if (!ground_s) begin
      gnd_cnt_r <= '0;
    end else if (!gnd_done) begin
      gnd_cnt_r <= gnd_cnt_r + rps_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      armed_r <= 1'b1;
    end else if (gnd_done) begin
      armed_r <= 1'b1;
    end else if (sup_ok_s) begin
      armed_r <= 1'b0;
    end
  end

  // Dips shorter than the minimum duration pass without a reset
  always_ff @(posedge i_clk) begin
    if (i_rst || !(below_s && bor_en)) begin
      dip_cnt_r <= '0;
    end else if (!bor_trip) begin
      dip_cnt_r <= dip_cnt_r + rps_pkg::CNT_W'(1);
    end
  end

  // Power-up delay counter, zero outside the delay state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lf_prev_r <= 1'b0;
    end else begin
      lf_prev_r <= lfosc_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !in_powerup_delay_timer) begin
      powerup_delay_timer_cnt_r <= '0;
    end else if (lf_tick) begin
      powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r + rps_pkg::POWERUP_DELAY_TIMER_W'(1);
    end
  end

  // Sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rps_pkg::ST_RUN: begin
        if (por_cond) begin
          st_nxt = rps_pkg::ST_POR;
        end else if (bor_trip) begin
          st_nxt = rps_pkg::ST_BOR;
        end else if (ext_low || i_wdt_reset) begin
          st_nxt = rps_pkg::ST_HOLD;
        end
      end
      rps_pkg::ST_POR: begin
        if (!por_cond && !below_s) begin
          st_nxt = after_sup;
        end
      end
      rps_pkg::ST_BOR: begin
        if (por_cond) begin
          st_nxt = rps_pkg::ST_POR;
        end else if (!below_s) begin
          st_nxt = after_sup;
        end
      end
      rps_pkg::ST_HOLD: begin
        if (por_cond) begin
          st_nxt = rps_pkg::ST_POR;
        end else if (bor_trip) begin
          st_nxt = rps_pkg::ST_BOR;
        end else if (!ext_low && !below_s) begin
          st_nxt = rps_pkg::ST_RUN;
        end
      end
      rps_pkg::ST_POWERUP_DELAY_TIMER: begin
        if (por_cond) begin
          st_nxt = rps_pkg::ST_POR;
        end else if (below_s) begin
          st_nxt = rps_pkg::ST_BOR;
        end else if (powerup_delay_timer_done) begin
          st_nxt = rps_pkg::ST_RUN;
        end
      end
      default: begin
        st_nxt = rps_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= rps_pkg::ST_POR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin-facing and analog-facing outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_chip_reset      <= 1'b1;
      o_brownout_det_en <= 1'b0;
      o_brownout_trim   <= rps_pkg::CAL_RST;
      o_pin3_pullup_en  <= 1'b0;
      o_pin3_oe_n       <= 1'b1;
    end else begin
      o_chip_reset      <= (st_nxt != rps_pkg::ST_RUN);
      o_brownout_det_en <= bor_en;
      o_brownout_trim   <= cal_r;
      o_pin3_pullup_en  <= ext_reset_pin_enable;
      o_pin3_oe_n       <= 1'b1;
    end
  end

  // Register bus decode; one wait cycle, then the answer
  wire req      = i_avs_read | i_avs_write;
  wire accept   = req & !wait_r;
  wire wr_acc   = accept & i_avs_write & i_avs_byteenable[0];
  wire cfg_spc  = (i_avs_address >= rps_pkg::ADDR_CFG_LO);
  wire sel_power_control_reg = (i_avs_address == rps_pkg::ADDR_POWER_CONTROL_REG);
  wire sel_stat = (i_avs_address == rps_pkg::ADDR_STATUS);
  wire sel_cfg  = prog_s && (i_avs_address == rps_pkg::ADDR_CFG);
  wire sel_cal  = prog_s && (i_avs_address == rps_pkg::ADDR_CAL);
  wire [7:0] wbyte = i_avs_writedata[7:0];
  wire [31:0] stat_word = {25'h0, armed_r, bor_en, st_r};
  wire [31:0] rd_mux = sel_power_control_reg ? {29'h0, power_control_reg_r} :
                       sel_stat ? stat_word :
                       sel_cfg  ? {28'h0000000, cfg_r} :
                       sel_cal  ? {24'h000000, cal_r} :
                       32'h00000000;
  wire cfg_blocked = cfg_spc & !prog_s; // Reads as zero, writes dropped

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r  <= !(req && wait_r);
      if (req && wait_r) begin
        rdata_r <= cfg_blocked ? 32'h00000000 : rd_mux;
      end
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata    = rdata_r;

  // Power control register: cause flags set by hardware, set beats clear
  wire set_porf = (st_nxt == rps_pkg::ST_POR) && (st_r != rps_pkg::ST_POR);
  wire set_borf = (st_nxt == rps_pkg::ST_BOR) && (st_r != rps_pkg::ST_BOR);
  wire wr_power_control_reg  = wr_acc & sel_power_control_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      power_control_reg_r <= rps_pkg::POWER_CONTROL_REG_RST;
    end else begin
      if (wr_power_control_reg) begin
        power_control_reg_r[rps_pkg::POWER_CONTROL_REG_SOFT_BROWNOUT_ENABLE] <= wbyte[rps_pkg::POWER_CONTROL_REG_SOFT_BROWNOUT_ENABLE];
      end
      if (set_porf) begin
        power_control_reg_r[rps_pkg::POWER_CONTROL_REG_PORF] <= 1'b1;
      end else if (wr_power_control_reg && wbyte[rps_pkg::POWER_CONTROL_REG_PORF]) begin
        power_control_reg_r[rps_pkg::POWER_CONTROL_REG_PORF] <= 1'b0;
      end
      if (set_borf) begin
        power_control_reg_r[rps_pkg::POWER_CONTROL_REG_BORF] <= 1'b1;
      end else if (wr_power_control_reg && wbyte[rps_pkg::POWER_CONTROL_REG_BORF]) begin
        power_control_reg_r[rps_pkg::POWER_CONTROL_REG_BORF] <= 1'b0;
      end
    end
  end

  // Fuses: bulk erase sets the configuration word to all ones, never calibration
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_r <= rps_pkg::CFG_ERASED;
      cal_r <= rps_pkg::CAL_RST;
    end else begin
      if (prog_s && i_bulk_erase) begin
        cfg_r <= rps_pkg::CFG_ERASED;
      end else if (wr_acc && sel_cfg) begin
        cfg_r <= wbyte[3:0];
      end
      if (wr_acc && sel_cal) begin
        cal_r <= wbyte;
      end
    end
  end
endmodule

// [rps_pkg.sv]
// Constants, states and register map of the reset and power-up sequencer
package rps_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
  localparam int unsigned POR_REARM_US  = 100;
  localparam int unsigned POR_REARM_CYC = (POR_REARM_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned BOR_MIN_US    = 100;
  localparam int unsigned BOR_MIN_CYC   = (BOR_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned PIN_FILT_NS   = 2000;
  localparam int unsigned PIN_FILT_CYC  = (PIN_FILT_NS * CLK_KHZ + 999_999)
                                          / 1_000_000;
  localparam int unsigned POWERUP_DELAY_TIMER_MS       = 64;
  localparam int unsigned LFOSC_HZ      = 31_000;
  localparam int unsigned POWERUP_DELAY_TIMER_LF_CYC   = 2048;
  localparam int unsigned CNT_W         = 12;
  localparam int unsigned POWERUP_DELAY_TIMER_W        = 11;

  // Synchronised inputs
  localparam int unsigned NIN        = 6;
  localparam int unsigned IN_PIN3    = 0;
  localparam int unsigned IN_SUP_OK  = 1;
  localparam int unsigned IN_BELOW   = 2;
  localparam int unsigned IN_GROUND  = 3;
  localparam int unsigned IN_LFOSC   = 4;
  localparam int unsigned IN_PROG    = 5;
  localparam int unsigned FILT_LEN [NIN] = '{PIN_FILT_CYC, 1, 1, 1, 1, 1};
  localparam logic [NIN-1:0] IN_RST_VAL  = 6'h05;

  // Bus map, byte addresses
  localparam logic [15:0] ADDR_POWER_CONTROL_REG    = 16'h0000;
  localparam logic [15:0] ADDR_STATUS  = 16'h0004;
  localparam int unsigned IDX_CFG_LO   = 32'h2000;
  localparam int unsigned IDX_CFG_WORD = 32'h2007;
  localparam int unsigned IDX_CAL_WORD = 32'h2008;
  localparam logic [15:0] ADDR_CFG_LO  = 16'(IDX_CFG_LO * 4);
  localparam logic [15:0] ADDR_CFG     = 16'(IDX_CFG_WORD * 4);
  localparam logic [15:0] ADDR_CAL     = 16'(IDX_CAL_WORD * 4);

  // Power control register fields
  localparam int unsigned POWER_CONTROL_REG_SOFT_BROWNOUT_ENABLE = 0;
  localparam int unsigned POWER_CONTROL_REG_PORF   = 1;
  localparam int unsigned POWER_CONTROL_REG_BORF   = 2;
  localparam logic [2:0]  POWER_CONTROL_REG_RST    = 3'h1;

  // Configuration word fields
  localparam int unsigned CFG_POWERUP_DELAY_TIMER_DIS = 0;
  localparam int unsigned CFG_EXT_RESET_PIN_ENABLE    = 1;
  localparam int unsigned CFG_BOR_LO   = 2;
  localparam int unsigned CFG_BOR_HI   = 3;
  localparam logic [3:0]  CFG_ERASED   = 4'hF;
  localparam logic [7:0]  CAL_RST      = 8'h80;

  typedef enum logic [1:0] {
    BOR_OFF  = 2'h0,
    BOR_SOFT = 2'h1,
    BOR_WAKE = 2'h2,
    BOR_ON   = 2'h3
  } rps_bor_mode_t;

  typedef enum logic [4:0] {
    ST_RUN  = 5'h01,
    ST_POR  = 5'h02,
    ST_BOR  = 5'h04,
    ST_HOLD = 5'h08,
    ST_POWERUP_DELAY_TIMER = 5'h10
  } rps_state_t;
endpackage

// [rps_filt_if.sv]
// Raw and cleaned level between the sequencer and an input filter
`timescale 1ns/1ps
interface rps_filt_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// [rps_sync_filt.sv]
// Three-stage synchroniser with a stability filter on its output
`timescale 1ns/1ps
module rps_sync_filt #(
  parameter int unsigned FILT    = 1,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  rps_filt_if.filt   port
);
  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic       clean_r;
  logic [7:0] cnt_r;
  wire        differs = (s2_r == s3_r) && (s3_r != clean_r);
  wire        settled = (cnt_r == 8'(FILT - 1));

  assign port.clean = clean_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= port.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Pulses shorter than FILT cycles never reach the output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clean_r <= RST_VAL;
      cnt_r   <= 8'h00;
    end else if (!differs) begin
      cnt_r   <= 8'h00;
    end else if (settled) begin
      clean_r <= s3_r;
      cnt_r   <= 8'h00;
    end else begin
      cnt_r   <= cnt_r + 8'h01;
    end
  end
endmodule

// [rps_check_sva.sv]
// Port-level checks of the reset sequencer
`timescale 1ns/1ps
module rps_check (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_ext_reset_n_pin,
  input wire logic        i_below_threshold,
  input wire logic        i_prog_mode,
  input wire logic        i_bulk_erase,
  input wire logic [15:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_chip_reset,
  input wire logic        o_brownout_det_en,
  input wire logic [7:0]  o_brownout_trim,
  input wire logic        o_pin3_pullup_en,
  input wire logic        o_pin3_oe_n
);
  logic [11:0] low_r;
  logic [7:0]  pin_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Run lengths; saturate so a long hold never wraps into a false match
  always_ff @(posedge i_clk) begin
    if (i_rst || !(i_below_threshold && o_brownout_det_en)) low_r <= 12'h000;
    else if (low_r != 12'hFFF) low_r <= low_r + 12'h001;
    if (i_rst || i_ext_reset_n_pin) pin_r <= 8'h00;
    else if (pin_r != 8'hFF) pin_r <= pin_r + 8'h01;
  end
  oe_never_a: assert property (o_pin3_oe_n)
    else $error("Pin 3 driven by the sequencer");
  wait_one_a: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("Late answer");
  wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("Answer held too long");
  cfg_hidden_a: assert property (!i_prog_mode [*5] ##0 i_avs_read &&
    o_avs_waitrequest && i_avs_address[15] |=> o_avs_readdata == 32'h0)
    else $error("Config space readable outside programming");
  trim_keep_a: assert property (!i_prog_mode [*6] |=>
    $stable(o_brownout_trim)) else $error("Trim changed outside programming");
  erase_keep_a: assert property (i_bulk_erase |=>
    $stable(o_brownout_trim) [*3]) else $error("Erase changed the trim");
  below_hold_a: assert property (i_below_threshold [*5] ##0
    o_chip_reset |=> o_chip_reset) else $error("Released while supply low");
  dip_reset_a: assert property (low_r == 12'h7DA |->
    ##[0:8] o_chip_reset) else $error("Long dip gave no reset");
  pin_reset_a: assert property (pin_r == 8'h32 && o_pin3_pullup_en |->
    ##[0:4] o_chip_reset) else $error("Held pin gave no reset");
  reset_rise_c: cover property ($rose(o_chip_reset));
  reset_fall_c: cover property ($fell(o_chip_reset));
  bus_write_c: cover property (!o_avs_waitrequest && i_avs_write);
endmodule
bind rps_top rps_check u_check (.i_clk, .i_rst, .i_ext_reset_n_pin,
  .i_below_threshold, .i_prog_mode, .i_bulk_erase, .i_avs_address,
  .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
  .o_chip_reset, .o_brownout_det_en, .o_brownout_trim, .o_pin3_pullup_en,
  .o_pin3_oe_n);

// [rps_supply_model.sv]
// Supply detectors, slow oscillator and reset pin around the sequencer
`timescale 1ns/1ps
module rps_supply_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_level,
  input  wire logic       i_press,
  input  wire logic       i_pullup,
  input  wire logic       i_oe_n,
  output logic            o_supply_ok,
  output logic            o_below,
  output logic            o_grounded,
  output logic            o_osc,
  output logic            o_pin
);
  logic [2:0] osc_cnt_r = 3'h0;
  logic       osc_r     = 1'b0;
  logic       float_r   = 1'b0;
  // Level 0 ground, 1 low, 2 dip, 3 good
  assign o_grounded  = (i_level == 2'h0);
  assign o_supply_ok = i_level[1];
  assign o_below     = (i_level != 2'h3);
  assign o_osc       = osc_r;
  // Unpulled pin wanders so a float cannot pass for high
  assign o_pin = (!i_oe_n || i_press) ? 1'b0 : (i_pullup | float_r);
  // Slow clock sped up to 10 cycles a period to keep the run short
  always_ff @(posedge i_clk) begin
    osc_cnt_r <= (osc_cnt_r == 3'h4) ? 3'h0 : osc_cnt_r + 3'h1;
    if (osc_cnt_r == 3'h4) osc_r <= !osc_r;
    float_r <= !float_r;
  end
endmodule

// [rps_top_bench.sv]
// Self-checking bench of the reset sequencer
`timescale 1ns/1ps
module rps_top_bench;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        prog  = 1'b0;
  logic        erase = 1'b0;
  logic        wdt   = 1'b0;
  logic        sleep = 1'b0;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic        press = 1'b0;
  logic [1:0]  level = 2'h0;
  logic [15:0] addr  = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rdo;
  logic        ok, below, gnd, osc, pin, wreq, crst, den, pull, oe_n, e;
  logic [7:0]  trim;
  int          mismatches = 0;
  int          compares   = 0;
  rps_supply_model partner (.i_clk(i_clk), .i_level(level), .i_press(press),
    .i_pullup(pull), .i_oe_n(oe_n), .o_supply_ok(ok), .o_below(below),
    .o_grounded(gnd), .o_osc(osc), .o_pin(pin));
  rps_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_ext_reset_n_pin(pin),
    .i_supply_ok(ok), .i_below_threshold(below), .i_supply_grounded(gnd),
    .i_low_freq_internal_osc(osc), .i_prog_mode(prog), .i_bulk_erase(erase),
    .i_wdt_reset(wdt), .i_sleep(sleep), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdo),
    .o_avs_waitrequest(wreq), .o_chip_reset(crst), .o_brownout_det_en(den),
    .o_brownout_trim(trim), .o_pin3_pullup_en(pull), .o_pin3_oe_n(oe_n));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rdata = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(n < 50, 1'b1);
  endtask
  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (crst !== v && n < lim) begin
      @(posedge i_clk);
      n++;
    end
    chk(crst, v);
  endtask
  task automatic hold(input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge i_clk);
      if (crst !== v) bad++;
    end
    chk(bad, 0);
  endtask
  task automatic close_out;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    i_rst <= 1'b0;
    hold(1'b1, 2500);
    level <= 2'h3;
    wait_rst(1'b0, 100);
    bus(1'b0, 16'h0004, 32'h0);
    chk(rdata[5:0], 6'h21);
    chk({pull, oe_n}, 2'h3);
    $display("Test powerup done");
    prog <= 1'b1;
    tick(10);
    bus(1'b1, 16'h8020, 32'h5A);
    bus(1'b1, 16'h801C, 32'hE);
    erase <= 1'b1;
    tick(1);
    erase <= 1'b0;
    bus(1'b0, 16'h8020, 32'h0);
    chk(rdata, 32'h5A);
    bus(1'b0, 16'h801C, 32'h0);
    chk(rdata, 32'hF);
    chk(trim, 8'h5A);
    bus(1'b1, 16'h801C, 32'hE);
    prog <= 1'b0;
    tick(10);
    bus(1'b1, 16'h8020, 32'h11);
    bus(1'b0, 16'h8020, 32'h0);
    chk(rdata, 32'h0);
    chk(trim, 8'h5A);
    bus(1'b0, 16'h0100, 32'h0);
    chk(rdata, 32'h0);
    $display("Test registers done");
    press <= 1'b1;
    tick(10);
    press <= 1'b0;
    hold(1'b0, 100);
    press <= 1'b1;
    wait_rst(1'b1, 100);
    press <= 1'b0;
    wait_rst(1'b0, 80);
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    wait_rst(1'b1, 5);
    chk(oe_n, 1'b1);
    wait_rst(1'b0, 50);
    $display("Test pin and watchdog done");
    level <= 2'h2;
    hold(1'b0, 100);
    level <= 2'h3;
    tick(20);
    level <= 2'h2;
    wait_rst(1'b1, 2100);
    hold(1'b1, 50);
    level <= 2'h3;
    hold(1'b1, 10000);
    level <= 2'h2;
    tick(50);
    level <= 2'h3;
    hold(1'b1, 19000);
    wait_rst(1'b0, 3000);
    bus(1'b0, 16'h0000, 32'h0);
    chk(rdata, 32'h5);
    bus(1'b1, 16'h0000, 32'h5);
    bus(1'b0, 16'h0000, 32'h0);
    chk(rdata, 32'h1);
    $display("Test brownout done");
    prog <= 1'b1;
    tick(10);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, 16'h801C, {28'h0, m[1:0], 2'h3});
        bus(1'b1, 16'h0000, {31'h0, k[0]});
        sleep <= k[1];
        tick(10);
        e = (m == 3) || (m == 1 && k[0]) || (m == 2 && !k[1]);
        chk(den, e);
      end
    end
    $display("Test modes done");
    bus(1'b1, 16'h801C, 32'h1);
    sleep <= 1'b0;
    tick(10);
    chk(pull, 1'b0);
    press <= 1'b1;
    hold(1'b0, 200);
    press <= 1'b0;
    level <= 2'h1;
    hold(1'b0, 3000);
    level <= 2'h0;
    wait_rst(1'b1, 2200);
    level <= 2'h3;
    wait_rst(1'b0, 100);
    $display("Test internal reset and power-on done");
    close_out();
  end
  initial begin
    tick(60000);
    mismatches++;
    close_out();
  end
endmodule
